// ### design/ctw_pkg.sv
// Purpose: constants for the transfer/test/wait decode block
// Assumes: 8-bit accumulator and index register, 16-bit addresses
// Notes:   cycle counts are whole instruction lengths
package ctw_pkg;
  // ==========================================
  // opcodes
  localparam logic [7:0] OP_MOVE_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OP_MOVE_INDEX_TO_ACC = 8'h9F;
  localparam logic [7:0] OP_TEST_DIR          = 8'h3D;
  localparam logic [7:0] OP_TEST_ACC          = 8'h4D;
  localparam logic [7:0] OP_TEST_INDEX        = 8'h5D;
  localparam logic [7:0] OP_TEST_SHORT_OFS    = 8'h6D;
  localparam logic [7:0] OP_TEST_INDEXED      = 8'h7D;
  localparam logic [7:0] OP_WAIT              = 8'h8F;
  localparam logic [7:0] OP_LONG_ADDR_LOAD    = 8'hC6;
  localparam logic [7:0] OP_LONG_OFS_LOAD     = 8'hD6;
  // ==========================================
  // cycle counts
  localparam logic [3:0] CYC_TRANSFER   = 4'h2;
  localparam logic [3:0] CYC_TEST_DIR   = 4'h4;
  localparam logic [3:0] CYC_TEST_REG   = 4'h3;
  localparam logic [3:0] CYC_TEST_SHORT = 4'h5;
  localparam logic [3:0] CYC_TEST_IX    = 4'h4;
  localparam logic [3:0] CYC_WAIT       = 4'h2;
  localparam logic [3:0] CYC_LONG_ADDR  = 4'h5;
  localparam logic [3:0] CYC_LONG_OFS   = 4'h5;
  localparam logic [3:0] CYC_OTHER      = 4'h2;
  // ==========================================
  // condition code bit positions and reset values
  localparam int          CC_C       = 0;
  localparam int          CC_Z       = 1;
  localparam int          CC_N       = 2;
  localparam int          CC_I       = 3;
  localparam int          CC_H       = 4;
  localparam logic [4:0]  CC_RESET   = 5'h08;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // ==========================================
  // sequencer states
  typedef enum logic [2:0] {
    CTW_IDLE, CTW_OPND1, CTW_OPND2, CTW_MEM, CTW_FINISH, CTW_WAITING
  } ctw_state_t;
  typedef enum logic [1:0] {
    CTW_SRC_ACC, CTW_SRC_IDX, CTW_SRC_MEM
  } ctw_src_t;
endpackage

// ### design/ctw_decode.sv
// Purpose: decode and execute transfer, test and wait instructions
// Assumes: fetch offers one byte per cycle with a valid flag; memory reads return data in the same cycle as mem_rd_out
// Notes:   other opcodes retire as two-cycle no-operations
// Functional notes
// - opcode 97 copies the accumulator into the index register, keeps all flags and takes 2 cycles.
// - opcode 9F copies the index register into the accumulator, keeps all flags and takes 2 cycles.
// - the test opcodes 3D, 4D, 5D, 6D, 7D set only negative and zero from operand minus zero, in 4, 3, 3, 5, 4 cycles.
// - opcode 8F clears the interrupt mask, keeps other flags and stops the cpu clock, listed at 2 cycles.
// - the long address form takes its address from two bytes after the opcode, high byte first.
// - the long offset indexed form takes two offset bytes, high first, and adds them to the index register.
// - the short offset indexed form takes one offset byte and adds it to the index register.
`timescale 1ns/100ps
`default_nettype none
module ctw_decode (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic        irq_in,
  output logic             byte_take_out,
  output logic             mem_rd_out,
  output logic [15:0]      mem_addr_out,
  output logic [7:0]       acc_out,
  output logic [7:0]       index_out,
  output logic [4:0]       cc_out,
  output logic             cpu_clk_en_out,
  output logic             retire_out,
  output logic [3:0]       cycles_out
);
  import ctw_pkg::*;

  // ==========================================
  // state
  ctw_state_t  state_q,  state_d;
  ctw_src_t    src_q,    src_d;
  logic [7:0]  op_q,     op_d;
  logic [7:0]  acc_q,    acc_d;
  logic [7:0]  idx_q,    idx_d;
  logic [4:0]  cc_q,     cc_d;
  logic [15:0] addr_q,   addr_d;
  logic [3:0]  cnt_q,    cnt_d;
  logic [3:0]  len_q,    len_d;
  logic        take_q,   take_d;
  logic        rd_q,     rd_d;
  logic        ret_q,    ret_d;
  logic        clken_q,  clken_d;
  logic [1:0]  irq_sync_q;
  logic [7:0]  tval;

  // ==========================================
  // operand value for the test
  always_comb begin
    case (src_q)
      CTW_SRC_ACC: tval = acc_q;
      CTW_SRC_IDX: tval = idx_q;
      default:     tval = mem_data_in;
    endcase
  end

  // ==========================================
  // sequencer next state
  always_comb begin
    state_d = state_q;
    src_d   = src_q;
    op_d    = op_q;
    acc_d   = acc_q;
    idx_d   = idx_q;
    cc_d    = cc_q;
    addr_d  = addr_q;
    len_d   = len_q;
    cnt_d   = cnt_q + 4'h1;
    take_d  = 1'b0;
    rd_d    = 1'b0;
    ret_d   = 1'b0;
    clken_d = clken_q;
    case (state_q)
      CTW_IDLE: begin
        cnt_d = 4'h1;
        if (byte_valid_in) begin
          take_d = 1'b1;
          op_d   = byte_in;
          case (byte_in)
            OP_MOVE_ACC_TO_INDEX: begin
              idx_d   = acc_q;
              len_d   = CYC_TRANSFER;
              state_d = CTW_FINISH;
            end
            OP_MOVE_INDEX_TO_ACC: begin
              acc_d   = idx_q;
              len_d   = CYC_TRANSFER;
              state_d = CTW_FINISH;
            end
            OP_TEST_ACC, OP_TEST_INDEX: begin
              src_d   = (byte_in == OP_TEST_ACC) ? CTW_SRC_ACC : CTW_SRC_IDX;
              len_d   = CYC_TEST_REG;
              state_d = CTW_MEM;
            end
            OP_TEST_DIR, OP_TEST_SHORT_OFS, OP_LONG_ADDR_LOAD, OP_LONG_OFS_LOAD: begin
              len_d   = (byte_in == OP_TEST_DIR) ? CYC_TEST_DIR :
                        (byte_in == OP_TEST_SHORT_OFS) ? CYC_TEST_SHORT :
                        (byte_in == OP_LONG_ADDR_LOAD) ? CYC_LONG_ADDR : CYC_LONG_OFS;
              state_d = CTW_OPND1;
            end
            OP_TEST_INDEXED: begin
              src_d   = CTW_SRC_MEM;
              addr_d  = {8'h00, idx_q};
              rd_d    = 1'b1;
              len_d   = CYC_TEST_IX;
              state_d = CTW_MEM;
            end
            OP_WAIT: begin
              cc_d[CC_I] = 1'b0;
              len_d      = CYC_WAIT;
              state_d    = CTW_FINISH;
            end
            default: begin
              len_d   = CYC_OTHER;
              state_d = CTW_FINISH;
            end
          endcase
        end
      end
      CTW_OPND1: begin
        if (byte_valid_in) begin
          take_d = 1'b1;
          src_d  = CTW_SRC_MEM;
          case (op_q)
            OP_TEST_DIR: begin
              addr_d  = {8'h00, byte_in};
              rd_d    = 1'b1;
              state_d = CTW_MEM;
            end
            OP_TEST_SHORT_OFS: begin
              addr_d  = 16'({8'h00, byte_in} + {8'h00, idx_q});
              rd_d    = 1'b1;
              state_d = CTW_MEM;
            end
            default: begin
              addr_d  = {byte_in, 8'h00};
              state_d = CTW_OPND2;
            end
          endcase
        end else begin
          cnt_d = cnt_q;
        end
      end
      CTW_OPND2: begin
        if (byte_valid_in) begin
          take_d = 1'b1;
          rd_d   = 1'b1;
          if (op_q == OP_LONG_OFS_LOAD) begin
            addr_d = 16'({addr_q[15:8], byte_in} + {8'h00, idx_q});
          end else begin
            addr_d = {addr_q[15:8], byte_in};
          end
          state_d = CTW_MEM;
        end else begin
          cnt_d = cnt_q;
        end
      end
      CTW_MEM: begin
        if (op_q == OP_LONG_ADDR_LOAD || op_q == OP_LONG_OFS_LOAD) begin
          acc_d = mem_data_in;
        end else begin
          cc_d[CC_N] = tval[7];
          cc_d[CC_Z] = (tval == 8'h00);
        end
        state_d = CTW_FINISH;
      end
      CTW_FINISH: begin
        if ((cnt_q + 4'h1) >= len_q) begin
          ret_d = 1'b1;
          if (op_q == OP_WAIT) begin
            clken_d = 1'b0;
            state_d = CTW_WAITING;
          end else begin
            state_d = CTW_IDLE;
          end
        end
      end
      CTW_WAITING: begin
        cnt_d = cnt_q;
        if (irq_sync_q[1]) begin
          clken_d = 1'b1;
          state_d = CTW_IDLE;
        end
      end
      default: state_d = CTW_IDLE;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q    <= CTW_IDLE;
      src_q      <= CTW_SRC_ACC;
      op_q       <= REG_RESET;
      acc_q      <= REG_RESET;
      idx_q      <= REG_RESET;
      cc_q       <= CC_RESET;
      addr_q     <= ADDR_RESET;
      cnt_q      <= 4'h0;
      len_q      <= 4'h0;
      take_q     <= 1'b0;
      rd_q       <= 1'b0;
      ret_q      <= 1'b0;
      clken_q    <= 1'b1;
      irq_sync_q <= 2'b00;
    end else begin
      state_q    <= state_d;
      src_q      <= src_d;
      op_q       <= op_d;
      acc_q      <= acc_d;
      idx_q      <= idx_d;
      cc_q       <= cc_d;
      addr_q     <= addr_d;
      cnt_q      <= cnt_d;
      len_q      <= len_d;
      take_q     <= take_d;
      rd_q       <= rd_d;
      ret_q      <= ret_d;
      clken_q    <= clken_d;
      irq_sync_q <= {irq_sync_q[0], irq_in};
    end
  end

  assign byte_take_out  = take_q;
  assign mem_rd_out     = rd_q;
  assign mem_addr_out   = addr_q;
  assign acc_out        = acc_q;
  assign index_out      = idx_q;
  assign cc_out         = cc_q;
  assign cpu_clk_en_out = clken_q;
  assign retire_out     = ret_q;
  assign cycles_out     = cnt_q;

  // ==========================================
  // checks
  a_move_to_index: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_IDLE && byte_valid_in && byte_in == OP_MOVE_ACC_TO_INDEX)
      |=> (idx_q == $past(acc_q) && cc_q == $past(cc_q)) ##1 (retire_out && cycles_out == 4'h2))
    else $error("acc to index transfer wrong");
  a_move_to_acc: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_IDLE && byte_valid_in && byte_in == OP_MOVE_INDEX_TO_ACC)
      |=> (acc_q == $past(idx_q) && cc_q == $past(cc_q)) ##1 (retire_out && cycles_out == 4'h2))
    else $error("index to acc transfer wrong");
  a_test_flags: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_MEM && op_q != OP_LONG_ADDR_LOAD && op_q != OP_LONG_OFS_LOAD)
      |=> (cc_q[CC_N] == $past(tval[7]) && cc_q[CC_Z] == ($past(tval) == 8'h00)
           && cc_q[CC_I] == $past(cc_q[CC_I]) && cc_q[CC_C] == $past(cc_q[CC_C])))
    else $error("test flags wrong");
  a_test_acc_len: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_IDLE && byte_valid_in && byte_in == OP_TEST_ACC) |=> ##2 (retire_out && cycles_out == 4'h3))
    else $error("register test length wrong");
  a_wait_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_IDLE && byte_valid_in && byte_in == OP_WAIT)
      |=> !cc_q[CC_I] ##1 (retire_out && !cpu_clk_en_out && cycles_out == 4'h2))
    else $error("wait did not stop clock");
  a_long_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_OPND2 && byte_valid_in && op_q == OP_LONG_ADDR_LOAD)
      |=> (mem_rd_out && mem_addr_out == {$past(addr_q[15:8]), $past(byte_in)}))
    else $error("long address wrong");
  a_long_offset: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_OPND2 && byte_valid_in && op_q == OP_LONG_OFS_LOAD)
      |=> (mem_addr_out == 16'({$past(addr_q[15:8]), $past(byte_in)} + {8'h00, $past(idx_q)})))
    else $error("long offset address wrong");
  a_short_offset: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_OPND1 && byte_valid_in && op_q == OP_TEST_SHORT_OFS)
      |=> (mem_rd_out && mem_addr_out == 16'({8'h00, $past(byte_in)} + {8'h00, $past(idx_q)})))
    else $error("short offset address wrong");
  a_wake_irq: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CTW_WAITING && irq_sync_q[1]) |=> (cpu_clk_en_out && state_q == CTW_IDLE))
    else $error("wait did not wake");
endmodule
`default_nettype wire

// ### tb/ctw_decode_tb.sv
// Purpose: self-checking bench for the transfer/test/wait decoder
// Assumes: one byte offered per cycle, memory data held from the issue of each instruction
// Notes:   inputs change on the falling edge; outputs sampled there too
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ctw_pkg::*;
  typedef struct {
    logic [7:0]  b0, b1, b2;
    int          n;
    logic [7:0]  mv;
    logic [3:0]  cyc;
    logic [7:0]  acc, idx;
    logic [4:0]  cc;
    logic        ccv;
    logic [15:0] addr;
    logic        av;
  } ctw_row_t;
  logic        clk_in        = 1'b0;
  logic        rst_in        = 1'b1;
  logic        byte_valid_in = 1'b0;
  logic        irq_in        = 1'b0;
  logic [7:0]  byte_in       = 8'h00;
  logic [7:0]  mem_data_in   = 8'h00;
  logic        byte_take_out, mem_rd_out, cpu_clk_en_out, retire_out;
  logic [15:0] mem_addr_out;
  logic [7:0]  acc_out, index_out;
  logic [4:0]  cc_out;
  logic [3:0]  cycles_out;
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc_cnt    = 0;
  bit          ok;
  ctw_row_t    rows[10];

  ctw_decode ctw_decode_inst (
    .clk_in(clk_in), .rst_in(rst_in), .byte_valid_in(byte_valid_in), .byte_in(byte_in),
    .mem_data_in(mem_data_in), .irq_in(irq_in), .byte_take_out(byte_take_out),
    .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out), .acc_out(acc_out),
    .index_out(index_out), .cc_out(cc_out), .cpu_clk_en_out(cpu_clk_en_out),
    .retire_out(retire_out), .cycles_out(cycles_out));

  always #12.5 clk_in = ~clk_in;

  // ==========================================
  // run control
  task automatic wrap_up();
    $display("counts: checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================
  // byte feed and completion wait
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
    logic [7:0] b[3];
    b = '{b0, b1, b2};
    for (int k = 0; k < n; k++) begin
      byte_valid_in = 1'b1;
      byte_in = b[k];
      @(negedge clk_in);
    end
    byte_valid_in = 1'b0;
  endtask

  task automatic wait_retire();
    ok = 0;
    for (int k = 0; k < 20 && !ok; k++) begin
      if (retire_out === 1'b1) ok = 1;
      else @(negedge clk_in);
    end
    check({15'h0000, ok}, 16'h0001);
  endtask

  // ==========================================
  // main sequence
  initial begin
    rows[0] = '{OP_LONG_ADDR_LOAD, 8'h12, 8'h34, 3, 8'h80, CYC_LONG_ADDR, 8'h80, 8'h00, 5'h00, 0, 16'h1234, 1};
    rows[1] = '{OP_TEST_ACC, 8'h00, 8'h00, 1, 8'h00, 4'h3, 8'h80, 8'h00, 5'h0C, 1, 16'h0000, 0};
    rows[2] = '{OP_MOVE_ACC_TO_INDEX, 8'h00, 8'h00, 1, 8'h00, 4'h2, 8'h80, 8'h80, 5'h0C, 1, 16'h0000, 0};
    rows[3] = '{OP_LONG_OFS_LOAD, 8'h01, 8'hFF, 3, 8'h00, CYC_LONG_OFS, 8'h00, 8'h80, 5'h00, 0, 16'h027F, 1};
    rows[4] = '{OP_TEST_INDEX, 8'h00, 8'h00, 1, 8'h00, 4'h3, 8'h00, 8'h80, 5'h0C, 1, 16'h0000, 0};
    rows[5] = '{OP_MOVE_INDEX_TO_ACC, 8'h00, 8'h00, 1, 8'h00, 4'h2, 8'h80, 8'h80, 5'h0C, 1, 16'h0000, 0};
    rows[6] = '{OP_TEST_DIR, 8'h40, 8'h00, 2, 8'h00, 4'h4, 8'h80, 8'h80, 5'h0A, 1, 16'h0040, 1};
    rows[7] = '{OP_TEST_SHORT_OFS, 8'h10, 8'h00, 2, 8'h7F, 4'h5, 8'h80, 8'h80, 5'h08, 1, 16'h0090, 1};
    rows[8] = '{OP_TEST_INDEXED, 8'h00, 8'h00, 1, 8'hFF, 4'h4, 8'h80, 8'h80, 5'h0C, 1, 16'h0080, 1};
    rows[9] = '{8'h9D, 8'h00, 8'h00, 1, 8'h00, CYC_OTHER, 8'h80, 8'h80, 5'h0C, 1, 16'h0000, 0};
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    // table of ordinary instructions, issued back to back
    for (int i = 0; i < 10; i++) begin
      mem_data_in = rows[i].mv;
      issue(rows[i].b0, rows[i].b1, rows[i].b2, rows[i].n);
      check({15'h0000, mem_rd_out}, {15'h0000, rows[i].av});
      wait_retire();
      check({12'h000, cycles_out}, {12'h000, rows[i].cyc});
      check({8'h00, acc_out}, {8'h00, rows[i].acc});
      check({8'h00, index_out}, {8'h00, rows[i].idx});
      if (rows[i].ccv) check({11'h000, cc_out}, {11'h000, rows[i].cc});
      if (rows[i].av) check(mem_addr_out, rows[i].addr);
      $display("row %0d done", i);
    end
    // wait: mask cleared, clock stopped, bytes refused, interrupt wakes
    issue(OP_WAIT, 8'h00, 8'h00, 1);
    wait_retire();
    check({12'h000, cycles_out}, {12'h000, CYC_WAIT});
    check({11'h000, cc_out}, 16'h0004);
    repeat (2) @(negedge clk_in);
    check({15'h0000, cpu_clk_en_out}, 16'h0000);
    byte_valid_in = 1'b1;
    byte_in = OP_MOVE_ACC_TO_INDEX;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_in);
      check({15'h0000, byte_take_out}, 16'h0000);
    end
    byte_valid_in = 1'b0;
    irq_in = 1'b1;
    ok = 0;
    for (int k = 0; k < 10 && !ok; k++) begin
      @(negedge clk_in);
      ok = (cpu_clk_en_out === 1'b1);
    end
    check({15'h0000, ok}, 16'h0001);
    irq_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check({8'h00, index_out}, 16'h0080);
    mem_data_in = 8'h00;
    issue(OP_TEST_DIR, 8'h40, 8'h00, 2);
    wait_retire();
    check({11'h000, cc_out}, 16'h0002);
    $display("wait with interrupt wake done");
    // wait, then reset wakes and restores
    issue(OP_WAIT, 8'h00, 8'h00, 1);
    wait_retire();
    repeat (2) @(negedge clk_in);
    rst_in = 1'b1;
    @(negedge clk_in);
    rst_in = 1'b0;
    check({15'h0000, cpu_clk_en_out}, 16'h0001);
    check({acc_out, index_out}, 16'h0000);
    check({11'h000, cc_out}, {11'h000, CC_RESET});
    check(mem_addr_out, ADDR_RESET);
    $display("wait with reset wake done");
    wrap_up();
  end
endmodule
`default_nettype wire
